// File: buffer_block_copy_engine.sv
// memory-to-memory copy engine with user and subcode pointer sets, APB slave
`timescale 1ns/1ns

// Behaviour
// - two copy engines sharing one byte mover: user and subcode
// - user engine moves exactly programmed byte count
// - writing copy-end bit aborts running copy
// - enabled subcode engine moves received blocks; while it runs, at most one more waits and later strobes are lost
// - only subcode source offset is software programmable
// - subcode engine re-arms itself for following blocks
// - control bit 7 selects user source interleave
// - control bit 6 selects user destination interleave
// - control bit 5 selects subcode source interleave
// - control bit 4 selects subcode destination interleave
// - control bit 3 enables user engine
// - control bit 2 enables subcode engine
// - control bit 1 skips Q byte de-interleave
// - control bit 0 selects subcode direction
// - copy end latched; write one clears it
module buffer_block_copy_engine #(
	parameter int ADDR_W = 18
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// buffer ram master, same clock
	output logic mem_req,
	output logic mem_we,
	output logic [23:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack,
	// subcode input side
	input wire logic subcode_block_done,
	input wire logic [11:0] subcode_fifo_segment,
	input wire logic [11:0] host_segment,
	// status
	output logic user_busy,
	output logic subcode_busy,
	output logic irq
);

	function automatic logic [11:0] il_offset(
		input logic [11:0] base,
		input logic [11:0] idx,
		input logic il_en,
		input logic q_raw
	);
		logic [11:0] lin;
		logic [11:0] row;
		lin = base + idx;
		row = base + (12'(idx[2:0]) * copy_engine_pkg::SUB_ROWS) + (idx >> 3);
		if (!il_en || (q_raw && idx[2:0] == copy_engine_pkg::SUB_Q_CHANNEL))
			return lin;
		return row;
	endfunction : il_offset

	function automatic logic [7:0] rd_hi(input logic [11:0] v);
		return {4'h0, v[11:8]};
	endfunction : rd_hi

	// register state
	logic [11:0] user_src_off_r;
	logic [11:0] user_dst_off_r;
	logic [11:0] user_src_seg_r;
	logic [11:0] user_dst_seg_r;
	logic [11:0] user_count_r;
	logic [11:0] sub_src_off_r;
	logic [11:0] sub_dst_off_r;
	logic [7:0] ctrl_r;
	logic [7:0] status_r;
	logic [7:0] mask_r;
	logic user_abort_r;

	// bus state
	logic [31:0] rd_nxt;
	logic map_hit;
	logic rd_status_r;
	logic acc_done;
	logic wr_en;
	logic [15:0] idx;

	// engine state
	copy_engine_pkg::move_state_t state_r;
	logic eng_sub_r;
	logic [11:0] u_idx_r;
	logic [11:0] s_idx_r;
	logic sub_pend_r;
	logic u_step;
	logic s_step;
	logic u_done;
	logic s_done;
	logic user_start;
	logic [11:0] s_src_off;
	logic [11:0] s_dst_off;
	logic s_src_il;
	logic s_dst_il;

	assign idx = 16'(paddr[ADDR_W-1:2]);
	assign acc_done = psel & penable & pready;
	assign wr_en = acc_done & pwrite & ~pslverr;
	// rewriting the control register while a copy runs does not restart it
	assign user_start = wr_en && idx == copy_engine_pkg::IDX_CONTROL
		&& pwdata[copy_engine_pkg::CTL_USER_EN] && !user_busy;

	// subcode direction swaps which side sees the interleaved layout
	assign s_src_il = ctrl_r[copy_engine_pkg::CTL_SUB_TX] ? ctrl_r[copy_engine_pkg::CTL_SUB_DST_IL]
		: ctrl_r[copy_engine_pkg::CTL_SUB_SRC_IL];
	assign s_dst_il = ctrl_r[copy_engine_pkg::CTL_SUB_TX] ? ctrl_r[copy_engine_pkg::CTL_SUB_SRC_IL]
		: ctrl_r[copy_engine_pkg::CTL_SUB_DST_IL];
	assign s_src_off = il_offset(sub_src_off_r, s_idx_r, s_src_il,
		ctrl_r[copy_engine_pkg::CTL_Q_RAW]);
	assign s_dst_off = il_offset(copy_engine_pkg::SUB_DST_BASE, s_idx_r, s_dst_il,
		ctrl_r[copy_engine_pkg::CTL_Q_RAW]);

	assign u_step = state_r == copy_engine_pkg::MV_WRITE && mem_ack && !eng_sub_r;
	assign s_step = state_r == copy_engine_pkg::MV_WRITE && mem_ack && eng_sub_r;
	assign u_done = u_step && user_count_r == 12'h001;
	assign s_done = s_step && s_idx_r == copy_engine_pkg::SUB_BLOCK_LEN - 12'h001;

	// read mux, sampled in the setup cycle
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		map_hit = 1'b1;
		unique case (idx)
			copy_engine_pkg::IDX_USER_SRC_OFF_HI: rd_nxt[7:0] = rd_hi(user_src_off_r);
			copy_engine_pkg::IDX_USER_SRC_OFF_LO: rd_nxt[7:0] = user_src_off_r[7:0];
			copy_engine_pkg::IDX_USER_DST_OFF_HI: rd_nxt[7:0] = rd_hi(user_dst_off_r);
			copy_engine_pkg::IDX_USER_DST_OFF_LO: rd_nxt[7:0] = user_dst_off_r[7:0];
			copy_engine_pkg::IDX_USER_SRC_SEG_HI: rd_nxt[7:0] = rd_hi(user_src_seg_r);
			copy_engine_pkg::IDX_USER_SRC_SEG_LO: rd_nxt[7:0] = user_src_seg_r[7:0];
			copy_engine_pkg::IDX_USER_DST_SEG_HI: rd_nxt[7:0] = rd_hi(user_dst_seg_r);
			copy_engine_pkg::IDX_USER_DST_SEG_LO: rd_nxt[7:0] = user_dst_seg_r[7:0];
			copy_engine_pkg::IDX_SUB_SRC_OFF_HI: rd_nxt[7:0] = rd_hi(sub_src_off_r);
			copy_engine_pkg::IDX_SUB_SRC_OFF_LO: rd_nxt[7:0] = sub_src_off_r[7:0];
			// destination offset bit 8 is not visible
			copy_engine_pkg::IDX_SUB_DST_OFF_HI: rd_nxt[7:0] = {4'h0, sub_dst_off_r[11:9], 1'b0};
			copy_engine_pkg::IDX_SUB_DST_OFF_LO: rd_nxt[7:0] = sub_dst_off_r[7:0];
			copy_engine_pkg::IDX_USER_COUNT_HI: rd_nxt[7:0] = rd_hi(user_count_r);
			copy_engine_pkg::IDX_USER_COUNT_LO: rd_nxt[7:0] = user_count_r[7:0];
			copy_engine_pkg::IDX_CONTROL: rd_nxt[7:0] = ctrl_r;
			copy_engine_pkg::IDX_GROUP_TWO_STATUS: rd_nxt[7:0] = status_r;
			copy_engine_pkg::IDX_GROUP_TWO_MASK: rd_nxt[7:0] = mask_r;
			default: map_hit = 1'b0;
		endcase
	end

	// apb handshake: one wait-free access cycle after setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			rd_status_r <= 1'b0;
		end
		else if (psel && !penable)
		begin
			prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
			pready <= 1'b1;
			pslverr <= ~map_hit;
			rd_status_r <= ~pwrite && idx == copy_engine_pkg::IDX_GROUP_TWO_STATUS;
		end
		else if (acc_done)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			rd_status_r <= 1'b0;
		end
	end

	// user engine registers; locked while its copy runs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			user_src_off_r <= copy_engine_pkg::PTR_RST;
			user_dst_off_r <= copy_engine_pkg::PTR_RST;
			user_src_seg_r <= copy_engine_pkg::PTR_RST;
			user_dst_seg_r <= copy_engine_pkg::PTR_RST;
			user_count_r <= copy_engine_pkg::PTR_RST;
		end
		else if (u_step)
			user_count_r <= user_count_r - 12'h001;
		else if (wr_en && !user_busy)
		begin
			unique case (idx)
				copy_engine_pkg::IDX_USER_SRC_OFF_HI: user_src_off_r[11:8] <= pwdata[3:0];
				copy_engine_pkg::IDX_USER_SRC_OFF_LO: user_src_off_r[7:0] <= pwdata[7:0];
				copy_engine_pkg::IDX_USER_DST_OFF_HI: user_dst_off_r[11:8] <= pwdata[3:0];
				copy_engine_pkg::IDX_USER_DST_OFF_LO: user_dst_off_r[7:0] <= pwdata[7:0];
				copy_engine_pkg::IDX_USER_SRC_SEG_HI: user_src_seg_r[11:8] <= pwdata[3:0];
				copy_engine_pkg::IDX_USER_SRC_SEG_LO: user_src_seg_r[7:0] <= pwdata[7:0];
				copy_engine_pkg::IDX_USER_DST_SEG_HI: user_dst_seg_r[11:8] <= pwdata[3:0];
				copy_engine_pkg::IDX_USER_DST_SEG_LO: user_dst_seg_r[7:0] <= pwdata[7:0];
				copy_engine_pkg::IDX_USER_COUNT_HI: user_count_r[11:8] <= pwdata[3:0];
				copy_engine_pkg::IDX_USER_COUNT_LO: user_count_r[7:0] <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// subcode source pointer: the only programmable subcode register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sub_src_off_r <= copy_engine_pkg::PTR_RST;
		else if (s_done)
			sub_src_off_r <= sub_src_off_r + copy_engine_pkg::SUB_BLOCK_LEN;
		else if (wr_en && idx == copy_engine_pkg::IDX_SUB_SRC_OFF_HI)
			sub_src_off_r[11:8] <= pwdata[3:0];
		else if (wr_en && idx == copy_engine_pkg::IDX_SUB_SRC_OFF_LO)
			sub_src_off_r[7:0] <= pwdata[7:0];
	end

	// control and mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= copy_engine_pkg::CONTROL_RST;
			mask_r <= copy_engine_pkg::MASK_RST;
		end
		else if (wr_en)
		begin
			if (idx == copy_engine_pkg::IDX_CONTROL)
				ctrl_r <= pwdata[7:0];
			if (idx == copy_engine_pkg::IDX_GROUP_TWO_MASK)
				mask_r <= pwdata[7:0];
		end
	end

	// abort request, honoured at the next byte boundary
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			user_abort_r <= 1'b0;
		else if (!user_busy || user_start)
			user_abort_r <= 1'b0;
		else if (wr_en && idx == copy_engine_pkg::IDX_GROUP_TWO_STATUS
			&& pwdata[copy_engine_pkg::ST_COPY_END])
			user_abort_r <= 1'b1;
	end

	// sticky status: a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_r <= copy_engine_pkg::STATUS_RST;
		else
		begin
			logic [7:0] clr;
			logic [7:0] set;
			clr = 8'h00;
			set = 8'h00;
			if (acc_done && rd_status_r)
				clr = prdata[7:0];
			if (wr_en && idx == copy_engine_pkg::IDX_GROUP_TWO_STATUS)
				clr = clr | pwdata[7:0];
			set[copy_engine_pkg::ST_COPY_END] = u_done;
			set[copy_engine_pkg::ST_SUB_BLOCK] = s_done;
			status_r <= (status_r & ~clr) | set;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(status_r & mask_r);
	end

	// received blocks queue one deep; a new strobe beats the take
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sub_pend_r <= 1'b0;
		else if (subcode_block_done && ctrl_r[copy_engine_pkg::CTL_SUB_EN])
			sub_pend_r <= 1'b1;
		else if (state_r == copy_engine_pkg::MV_IDLE && !subcode_busy)
			sub_pend_r <= 1'b0;
	end

	// byte mover: subcode has priority, it must keep pace with the disc
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= copy_engine_pkg::MV_IDLE;
			eng_sub_r <= 1'b0;
			u_idx_r <= copy_engine_pkg::PTR_RST;
			s_idx_r <= copy_engine_pkg::PTR_RST;
			user_busy <= 1'b0;
			subcode_busy <= 1'b0;
			sub_dst_off_r <= copy_engine_pkg::PTR_RST;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 24'h00_0000;
			mem_wdata <= 8'h00;
		end
		else
		begin
			if (user_start && user_count_r != 12'h000)
			begin
				user_busy <= 1'b1;
				u_idx_r <= 12'h000;
			end
			unique case (state_r)
				copy_engine_pkg::MV_IDLE:
				begin
					if (subcode_busy)
					begin
						eng_sub_r <= 1'b1;
						mem_req <= 1'b1;
						mem_we <= 1'b0;
						mem_addr <= {subcode_fifo_segment, s_src_off};
						state_r <= copy_engine_pkg::MV_READ;
					end
					else if (sub_pend_r && ctrl_r[copy_engine_pkg::CTL_SUB_EN])
					begin
						subcode_busy <= 1'b1;
						s_idx_r <= 12'h000;
					end
					else if (user_busy)
					begin
						if (user_abort_r || !ctrl_r[copy_engine_pkg::CTL_USER_EN]
							|| user_count_r == 12'h000)
							user_busy <= 1'b0;
						else
						begin
							eng_sub_r <= 1'b0;
							mem_req <= 1'b1;
							mem_we <= 1'b0;
							mem_addr <= {user_src_seg_r, il_offset(user_src_off_r, u_idx_r,
								ctrl_r[copy_engine_pkg::CTL_USER_SRC_IL], 1'b0)};
							state_r <= copy_engine_pkg::MV_READ;
						end
					end
				end
				copy_engine_pkg::MV_READ:
				begin
					if (mem_ack)
					begin
						mem_we <= 1'b1;
						mem_wdata <= mem_rdata;
						if (eng_sub_r)
						begin
							mem_addr <= {host_segment, s_dst_off};
							sub_dst_off_r <= s_dst_off;
						end
						else
							mem_addr <= {user_dst_seg_r, il_offset(user_dst_off_r, u_idx_r,
								ctrl_r[copy_engine_pkg::CTL_USER_DST_IL], 1'b0)};
						state_r <= copy_engine_pkg::MV_WRITE;
					end
				end
				copy_engine_pkg::MV_WRITE:
				begin
					if (mem_ack)
					begin
						mem_req <= 1'b0;
						mem_we <= 1'b0;
						state_r <= copy_engine_pkg::MV_IDLE;
						if (eng_sub_r)
						begin
							s_idx_r <= s_idx_r + 12'h001;
							if (s_done)
								subcode_busy <= 1'b0;
						end
						else
							u_idx_r <= u_idx_r + 12'h001;
					end
				end
				default: state_r <= copy_engine_pkg::MV_IDLE;
			endcase
		end
	end

endmodule : buffer_block_copy_engine

// File: copy_engine_pkg.sv
// shared constants for the buffer block copy engine
package copy_engine_pkg;

	// register indices; byte address on the bus is four times the index
	localparam logic [15:0] IDX_USER_SRC_OFF_HI = 16'hff36;
	localparam logic [15:0] IDX_USER_SRC_OFF_LO = 16'hff37;
	localparam logic [15:0] IDX_USER_DST_OFF_HI = 16'hff38;
	localparam logic [15:0] IDX_USER_DST_OFF_LO = 16'hff39;
	localparam logic [15:0] IDX_USER_SRC_SEG_HI = 16'hff3a;
	localparam logic [15:0] IDX_USER_SRC_SEG_LO = 16'hff3b;
	localparam logic [15:0] IDX_USER_DST_SEG_HI = 16'hff3c;
	localparam logic [15:0] IDX_USER_DST_SEG_LO = 16'hff3d;
	localparam logic [15:0] IDX_SUB_SRC_OFF_HI = 16'hff3e;
	localparam logic [15:0] IDX_SUB_SRC_OFF_LO = 16'hff3f;
	localparam logic [15:0] IDX_SUB_DST_OFF_HI = 16'hff40;
	localparam logic [15:0] IDX_SUB_DST_OFF_LO = 16'hff41;
	localparam logic [15:0] IDX_USER_COUNT_HI = 16'hff62;
	localparam logic [15:0] IDX_USER_COUNT_LO = 16'hff63;
	localparam logic [15:0] IDX_CONTROL = 16'hff67;
	// status reads here, write-one clears at the same index
	localparam logic [15:0] IDX_GROUP_TWO_STATUS = 16'hff7c;
	localparam logic [15:0] IDX_GROUP_TWO_MASK = 16'hff7d;

	// control bit positions
	localparam int CTL_USER_SRC_IL = 7;
	localparam int CTL_USER_DST_IL = 6;
	localparam int CTL_SUB_SRC_IL = 5;
	localparam int CTL_SUB_DST_IL = 4;
	localparam int CTL_USER_EN = 3;
	localparam int CTL_SUB_EN = 2;
	localparam int CTL_Q_RAW = 1;
	localparam int CTL_SUB_TX = 0;

	// status bit positions in the second drive group
	localparam int ST_COPY_END = 4;
	localparam int ST_SUB_BLOCK = 3;

	// values after reset
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [11:0] PTR_RST = 12'h000;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;

	// subcode block geometry: eight channel bytes per symbol
	localparam logic [11:0] SUB_BLOCK_LEN = 12'h060;
	localparam logic [11:0] SUB_ROWS = 12'h00c;
	localparam logic [11:0] SUB_DST_BASE = 12'h000;
	localparam logic [2:0] SUB_Q_CHANNEL = 3'h1;

	typedef enum logic [1:0] {
		MV_IDLE,
		MV_READ,
		MV_WRITE
	} move_state_t;

endpackage : copy_engine_pkg

// File: copy_engine_ram_model.sv
// buffer ram partner model with selectable answer latency
`timescale 1ns/1ns
module copy_engine_ram_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// engine side
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	// latency select
	input wire logic slow,
	output logic [7:0] mem_rdata,
	output logic mem_ack
);
	logic [7:0] m [int];
	int wt;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= 8'h00;
			wt <= 0;
		end
		else
		begin
			mem_ack <= 1'b0;
			// outside an answer the byte on the bus is inverted every cycle
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && wt < (slow ? 2 : 0))
				wt <= wt + 1;
			else if (mem_req && !mem_ack)
			begin
				wt <= 0;
				mem_ack <= 1'b1;
				if (mem_we)
					m[mem_addr] = mem_wdata;
				else if (m.exists(mem_addr))
					mem_rdata <= m[mem_addr];
				else
					mem_rdata <= mem_addr[7:0] ^ mem_addr[19:12];
			end
		end
	end
endmodule : copy_engine_ram_model

// File: buffer_block_copy_engine_checker.sv
// port assertions for the buffer block copy engine
`timescale 1ns/1ns
module buffer_block_copy_engine_checker #(
	parameter int ADDR_W = 18
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// buffer ram
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack,
	// status
	input wire logic [11:0] host_segment,
	input wire logic user_busy,
	input wire logic subcode_busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_only: assert property (pready |-> $past(psel && !penable) && psel)
		else $error("ready outside access");
	chk_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_req_hold: assert property (mem_req && !mem_ack |=>
		mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("ram request changed before ack");
	chk_write_copy: assert property (mem_req && !mem_we && mem_ack |=>
		mem_req && mem_we && mem_wdata == $past(mem_rdata))
		else $error("written byte differs from read byte");
	chk_idle_gap: assert property (mem_req && mem_we && mem_ack |=> !mem_req)
		else $error("no idle cycle after byte");
	chk_req_busy: assert property (mem_req |-> user_busy || subcode_busy)
		else $error("ram access while idle");
	chk_sub_seg: assert property (subcode_busy && !user_busy && mem_req && mem_we |->
		mem_addr[23:12] == host_segment)
		else $error("subcode written outside host segment");
endmodule : buffer_block_copy_engine_checker

bind buffer_block_copy_engine buffer_block_copy_engine_checker #(.ADDR_W(ADDR_W)) chk (
	.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr, .mem_req, .mem_we,
	.mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .host_segment, .user_busy, .subcode_busy);

// File: buffer_block_copy_engine_tb_top.sv
// self-checking bench for the buffer block copy engine
`timescale 1ns/1ns
module buffer_block_copy_engine_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, subcode_block_done = 1'b0, slow = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, mem_req, mem_we, mem_ack, user_busy, subcode_busy, irq, er;
	logic [23:0] mem_addr, sa, da;
	logic [7:0] mem_wdata, mem_rdata, c;
	logic [11:0] subcode_fifo_segment = 12'h003, host_segment = 12'h004, s;
	int error_cnt = 0, n_tests = 0;

	buffer_block_copy_engine #(.ADDR_W(18)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack, .subcode_block_done, .subcode_fifo_segment,
		.host_segment, .user_busy, .subcode_busy, .irq);
	copy_engine_ram_model ram (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.slow, .mem_rdata, .mem_ack);

	initial forever #10 pclk = ~pclk;

	function automatic logic [7:0] dv(input logic [23:0] a);
		return a[7:0] ^ a[19:12];
	endfunction : dv
	// place of byte i in a block of eight interleaved channels
	function automatic logic [11:0] il(input int i, input logic on, input logic q);
		if (on && !(q && i % 8 == 1))
			return 12'((i % 8) * 12 + i / 8);
		return 12'(i);
	endfunction : il

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic apb(input logic [15:0] idx, input logic w, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no own limit: only the watchdog ends a wait for the slave
		while (pready !== 1'b1)
			@(posedge pclk);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
		apb(idx, 1'b0, 8'h00);
		chk(rv, exp);
	endtask : rd

	task automatic w12(input logic [15:0] hi, input logic [11:0] v);
		wr(hi, {4'h0, v[11:8]});
		wr(hi + 16'h1, v[7:0]);
	endtask : w12

	task automatic pulse();
		@(posedge pclk);
		subcode_block_done <= 1'b1;
		@(posedge pclk);
		subcode_block_done <= 1'b0;
	endtask : pulse

	task automatic wait_busy(input logic sub);
		int n;
		n = 0;
		while ((sub ? subcode_busy : user_busy) !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		chk(n < 20, 1'b1);
		while ((sub ? subcode_busy : user_busy) !== 1'b0 && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		chk(n < 3000, 1'b1);
		repeat (2) @(posedge pclk);
	endtask : wait_busy

	task automatic setup(input logic [11:0] dseg, input logic [11:0] cnt);
		w12(copy_engine_pkg::IDX_USER_SRC_SEG_HI, 12'h001);
		w12(copy_engine_pkg::IDX_USER_SRC_OFF_HI, 12'h010);
		w12(copy_engine_pkg::IDX_USER_DST_SEG_HI, dseg);
		w12(copy_engine_pkg::IDX_USER_DST_OFF_HI, 12'h020);
		w12(copy_engine_pkg::IDX_USER_COUNT_HI, cnt);
	endtask : setup

	task automatic t_regs();
		rd(copy_engine_pkg::IDX_CONTROL, copy_engine_pkg::CONTROL_RST);
		rd(copy_engine_pkg::IDX_GROUP_TWO_STATUS, copy_engine_pkg::STATUS_RST);
		w12(copy_engine_pkg::IDX_USER_SRC_OFF_HI, 12'h5a7);
		rd(copy_engine_pkg::IDX_USER_SRC_OFF_HI, 32'h5);
		rd(copy_engine_pkg::IDX_USER_SRC_OFF_LO, 32'ha7);
		wr(copy_engine_pkg::IDX_SUB_DST_OFF_LO, 8'h33);
		rd(copy_engine_pkg::IDX_SUB_DST_OFF_LO, 32'h0);
		apb(16'h0000, 1'b0, 8'h00);
		chk(er, 1'b1);
		setup(12'h020, 12'h004);
		wr(copy_engine_pkg::IDX_CONTROL, 8'h00);
		pulse();
		repeat (5) @(posedge pclk);
		chk(user_busy, 1'b0);
		chk(subcode_busy, 1'b0);
	endtask : t_regs

	task automatic t_user();
		for (int k = 0; k < 3; k++)
		begin
			c = k == 0 ? 8'h08 : (k == 1 ? 8'h88 : 8'h48);
			s = 12'h020 + 12'(k);
			setup(s, 12'h009);
			wr(copy_engine_pkg::IDX_GROUP_TWO_MASK, k == 0 ? 8'h00 : 8'h10);
			wr(copy_engine_pkg::IDX_CONTROL, c);
			wait_busy(1'b0);
			for (int i = 0; i < 9; i++)
			begin
				da = {s, 12'h020 + il(i, c[6], 1'b0)};
				sa = {12'h001, 12'h010 + il(i, c[7], 1'b0)};
				chk(ram.m[da], dv(sa));
			end
			chk(ram.m.exists({s, 12'h020 + il(9, c[6], 0)}), 1'b0);
			chk(irq, k != 0);
			// last pass clears by write-one instead of by the read
			if (k == 2)
				wr(copy_engine_pkg::IDX_GROUP_TWO_STATUS, 8'h10);
			rd(copy_engine_pkg::IDX_GROUP_TWO_STATUS, k == 2 ? 32'h0 : 32'h10);
			repeat (2) @(posedge pclk);
			chk(irq, 1'b0);
		end
	endtask : t_user

	task automatic t_abort();
		setup(12'h030, 12'h0c8);
		wr(copy_engine_pkg::IDX_CONTROL, 8'h08);
		repeat (10) @(posedge pclk);
		chk(user_busy, 1'b1);
		wr(copy_engine_pkg::IDX_GROUP_TWO_STATUS, 8'h10);
		repeat (6) @(posedge pclk);
		chk(user_busy, 1'b0);
		chk(ram.m.exists({12'h030, 12'h020 + 12'h0c7}), 1'b0);
		// restart on the remaining count, then stop by clearing the enable
		wr(copy_engine_pkg::IDX_CONTROL, 8'h08);
		repeat (10) @(posedge pclk);
		chk(user_busy, 1'b1);
		wr(copy_engine_pkg::IDX_CONTROL, 8'h00);
		repeat (6) @(posedge pclk);
		chk(user_busy, 1'b0);
		rd(copy_engine_pkg::IDX_GROUP_TWO_STATUS, 32'h0);
	endtask : t_abort

	task automatic t_sub();
		wr(copy_engine_pkg::IDX_CONTROL, 8'h00);
		w12(copy_engine_pkg::IDX_SUB_SRC_OFF_HI, 12'h100);
		wr(copy_engine_pkg::IDX_GROUP_TWO_MASK, 8'h08);
		for (int k = 0; k < 4; k++)
		begin
			c = k == 0 ? 8'h04 : (k == 1 ? 8'h24 : (k == 2 ? 8'h26 : 8'h15));
			wr(copy_engine_pkg::IDX_CONTROL, c);
			slow <= k[0];
			host_segment <= 12'h004 + 12'(k);
			pulse();
			wait_busy(1'b1);
			s = 12'h100 + 12'(96 * k);
			for (int i = 0; i < 96; i++)
			begin
				da = {12'h004 + 12'(k), il(i, c[0] ? c[5] : c[4], c[1])};
				sa = {12'h003, s + il(i, c[0] ? c[4] : c[5], c[1])};
				chk(ram.m[da], dv(sa));
			end
			chk(irq, 1'b1);
			rd(copy_engine_pkg::IDX_GROUP_TWO_STATUS, 32'h08);
		end
	endtask : t_sub

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_user();
		t_abort();
		t_sub();
		stop_test();
	end

	// a hung handshake ends the run well past the expected few thousand cycles
	initial
	begin
		#1000000;
		error_cnt++;
		stop_test();
	end
endmodule : buffer_block_copy_engine_tb_top
